// ==== core/ebt_pkg.sv ====
// package of the eight-channel byte timer group
// assumes an apb slave with 32-bit data, byte offsets times four
package ebt_pkg;
  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_RUN   = 8'h20;
  localparam logic [7:0] IDX_DBUF  = 8'h21;
  localparam logic [7:0] IDX_CMP0  = 8'h22;
  localparam logic [7:0] IDX_CMP1  = 8'h23;
  localparam logic [7:0] IDX_MOD01 = 8'h24;
  localparam logic [7:0] IDX_FFC02 = 8'h25;
  localparam logic [7:0] IDX_CMP2  = 8'h26;
  localparam logic [7:0] IDX_CMP3  = 8'h27;
  localparam logic [7:0] IDX_MOD23 = 8'h28;
  localparam logic [7:0] IDX_CMP4  = 8'h29;
  localparam logic [7:0] IDX_CMP5  = 8'h2a;
  localparam logic [7:0] IDX_MOD45 = 8'h2b;
  localparam logic [7:0] IDX_FFC46 = 8'h2c;
  localparam logic [7:0] IDX_CMP6  = 8'h2d;
  localparam logic [7:0] IDX_CMP7  = 8'h2e;
  localparam logic [7:0] IDX_MOD67 = 8'h2f;
  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RUN   = 8'h00;
  localparam logic [3:0] RST_DBUF  = 4'h0;
  localparam logic [7:0] RST_MOD   = 8'h00;
  localparam logic [7:0] RST_FFC   = 8'hcc;
  localparam int         MOD_OP_LSB  = 6;
  localparam int         MOD_PWM_LSB = 4;
  localparam int         MOD_CKH_LSB = 2;
  localparam int         MOD_CKL_LSB = 0;
  localparam int         FFC_HI_LSB  = 4;
  localparam int         FFC_LO_LSB  = 0;
  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EBT_OP_8BIT = 2'b00,
    EBT_OP_16   = 2'b01,
    EBT_OP_PPG  = 2'b10,
    EBT_OP_PWM  = 2'b11
  } ebt_op_t;
  typedef enum logic [1:0] {
    EBT_FF_INV  = 2'b00,
    EBT_FF_SET  = 2'b01,
    EBT_FF_CLR  = 2'b10,
    EBT_FF_KEEP = 2'b11
  } ebt_ffcmd_t;
  // one pair mode register
  typedef struct packed {
    ebt_op_t    op;
    logic [1:0] pwm;
    logic [1:0] ck_hi;
    logic [1:0] ck_lo;
  } ebt_mode_t;
  // timer clock sources shared by all pairs
  typedef struct packed {
    logic       t1;
    logic       t4;
    logic       t16;
    logic       t256;
  } ebt_tick_t;
endpackage : ebt_pkg

// ==== core/ebt_timer_group.sv ====
// eight 8-bit interval timers in four pairs with apb registers
// assumes synchronous prescaler ticks and external inputs, one clock
//
// Summary of operation
// R1 - run bit per timer; zero stops, clears
// R2 - double buffer enables for compares 6,4,2,0
// R3 - pair mode: 8bit, 16bit cascade, ppg, pwm
// R4 - pwm cycle codes 63, 127, 255 counts
// R5 - flip-flop command codes; auto-invert enable bit
// R6 - source bit picks lower or higher timer
// R7 - compare registers write-only, no reset value
// R8 - match pulses: flip-flop, cascade, counter clear
`timescale 1ns/100ps
module ebt_timer_group #(
  parameter int NTMR = 8
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire ebt_pkg::ebt_tick_t   tick,
  input  wire logic [NTMR-1:0]      ext_in,
  output logic      [3:0]           timer_output_flipflop
);
  import ebt_pkg::*;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire        acc    = psel & penable;
  wire        wr_en  = acc & pwrite;
  wire        al_ok  = (paddr[1:0] == 2'b00);
  wire [7:0]  idx    = paddr[9:2];
  wire        hi_ok  = (paddr[11:10] == 2'b00) & al_ok;

  logic [7:0]      run_q;
  logic [3:0]      dbuf_q;
  ebt_mode_t [3:0] mode_q;
  logic [7:0]      ffc_q [2];
  logic [7:0]      cmp_q [NTMR];
  logic [7:0]      cbuf_q [NTMR];
  logic [7:0]      cnt_q [NTMR];
  logic [3:0]      tff_q;
  logic [31:0]     prdata_q;
  logic            pready_q;
  logic            pslverr_q;

  function automatic int cmp_slot(input logic [7:0] i);
    case (i)
      IDX_CMP0: cmp_slot = 0;
      IDX_CMP1: cmp_slot = 1;
      IDX_CMP2: cmp_slot = 2;
      IDX_CMP3: cmp_slot = 3;
      IDX_CMP4: cmp_slot = 4;
      IDX_CMP5: cmp_slot = 5;
      IDX_CMP6: cmp_slot = 6;
      IDX_CMP7: cmp_slot = 7;
      default:  cmp_slot = -1;
    endcase
  endfunction : cmp_slot

  function automatic int mod_slot(input logic [7:0] i);
    case (i)
      IDX_MOD01: mod_slot = 0;
      IDX_MOD23: mod_slot = 1;
      IDX_MOD45: mod_slot = 2;
      IDX_MOD67: mod_slot = 3;
      default:   mod_slot = -1;
    endcase
  endfunction : mod_slot

  int        cslot;
  int        mslot;
  assign cslot = cmp_slot(idx);
  assign mslot = mod_slot(idx);
  wire       is_ffc = (idx == IDX_FFC02) | (idx == IDX_FFC46);
  wire       ffsel  = (idx == IDX_FFC46);
  wire       mapped = hi_ok & ((idx == IDX_RUN) | (idx == IDX_DBUF) |
                       (cslot >= 0) | (mslot >= 0) | is_ffc);
  // compare registers answer reads with an error
  wire       bad    = ~mapped | (~pwrite & (cslot >= 0)); // R7

  // read data: ffc command fields read back as 11
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (idx == IDX_RUN)
      rd_byte = run_q;
    else if (idx == IDX_DBUF)
      rd_byte = {4'h0, dbuf_q};
    else if (mslot >= 0)
      rd_byte = mode_q[mslot[1:0]];
    else if (is_ffc)
      rd_byte = {2'b11, ffc_q[ffsel][5:4], 2'b11, ffc_q[ffsel][1:0]};
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  function automatic logic pick_tick(input logic [1:0] s,
                                     input logic       alt,
                                     input ebt_tick_t  t);
    case (s)
      2'b00:   pick_tick = alt;
      2'b01:   pick_tick = t.t1;
      2'b10:   pick_tick = t.t16;
      default: pick_tick = t.t256;
    endcase
  endfunction : pick_tick

  logic [NTMR-1:0] step;
  logic [NTMR-1:0] match;
  logic [NTMR-1:0] clr;
  logic [3:0]      wrap;
  // one pulse per period: a held match must not retrigger
  wire  [NTMR-1:0] hit = match & step; // R8

  // pwm period is 2^n-1 ticks, last count 2^n-2; code 00 leaves 2^8-1
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      case (mode_q[p].pwm)
        2'b01:   wrap[p] = (cnt_q[2*p] == 8'h3e); // R4
        2'b10:   wrap[p] = (cnt_q[2*p] == 8'h7e); // R4
        default: wrap[p] = (cnt_q[2*p] == 8'hfe); // R4
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < NTMR; i++) begin
      match[i] = run_q[i] & (cnt_q[i] == cmp_q[i]); // R8
    end
    for (int p = 0; p < 4; p++) begin
      // low timer: even index uses t1/t4/t16 or external input
      step[2*p] = run_q[2*p] & ((mode_q[p].ck_lo == 2'b00) ? ext_in[2*p] :
                  (mode_q[p].ck_lo == 2'b01) ? tick.t1 :
                  (mode_q[p].ck_lo == 2'b10) ? tick.t4 : tick.t16);
      // high timer: code 00 cascades from low timer match
      step[2*p+1] = run_q[2*p+1] &
                    pick_tick(mode_q[p].ck_hi,
                              match[2*p] & step[2*p], tick); // R8
      clr[2*p]   = 1'b0;
      clr[2*p+1] = 1'b0;
      case (mode_q[p].op)
        EBT_OP_8BIT: begin // R3
          clr[2*p]   = match[2*p] & step[2*p]; // R8
          clr[2*p+1] = match[2*p+1] & step[2*p+1]; // R8
        end
        EBT_OP_16: begin // R3
          // high counter steps on low wrap; clears on joint match
          step[2*p+1] = run_q[2*p+1] & step[2*p] & (cnt_q[2*p] == 8'hff);
          clr[2*p]    = match[2*p] & match[2*p+1] & step[2*p];
          clr[2*p+1]  = clr[2*p];
        end
        EBT_OP_PPG: begin // R3
          clr[2*p] = match[2*p+1] & step[2*p]; // R8
        end
        EBT_OP_PWM: begin // R3
          clr[2*p] = wrap[p] & step[2*p]; // R4
        end
        default: begin
          clr[2*p] = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // flip-flop control (ffc02 holds ff1/ff3, ffc46 holds ff5/ff7)
  // ----------------------------------------------------------------
  // each output flip-flop inverts on the match of the timer chosen in its pair
  logic [3:0] ff_trig;
  logic [3:0] ff_next;
  always_comb begin
    for (int f = 0; f < 4; f++) begin
      logic [7:0] r;
      logic [3:0] nib;
      int         pr;
      r   = ffc_q[f/2];
      nib = (f % 2 == 1) ? r[7:4] : r[3:0];
      // ffc02 serves pairs 0 and 1, ffc46 pairs 2 and 3
      pr  = f;
      ff_trig[f] = nib[1] & (nib[0] ? hit[2*pr+1] : hit[2*pr]); // R6
      ff_next[f] = ff_trig[f] ? ~tff_q[f] : tff_q[f]; // R5
    end
    if (wr_en & hi_ok & is_ffc) begin
      for (int h = 0; h < 2; h++) begin
        logic [1:0] cmd;
        int         f2;
        cmd = pwdata[FFC_LO_LSB + 4*h + 2 +: 2];
        f2  = 2*(ffsel ? 1 : 0) + h;
        case (ebt_ffcmd_t'(cmd)) // R5
          EBT_FF_INV:  ff_next[f2] = ~tff_q[f2];
          EBT_FF_SET:  ff_next[f2] = 1'b1;
          EBT_FF_CLR:  ff_next[f2] = 1'b0;
          default:     ff_next[f2] = ff_next[f2];
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q    <= RST_RUN; // R1
      dbuf_q   <= RST_DBUF; // R2
      mode_q   <= {4{RST_MOD}}; // R3
      ffc_q[0] <= RST_FFC; // R5
      ffc_q[1] <= RST_FFC; // R6
      tff_q    <= 4'h0;
      for (int i = 0; i < NTMR; i++)
        cnt_q[i] <= 8'h00;
    end else begin
      tff_q <= ff_next;
      for (int i = 0; i < NTMR; i++) begin
        if (!run_q[i] || clr[i])
          cnt_q[i] <= 8'h00; // R1
        else if (step[i])
          cnt_q[i] <= cnt_q[i] + 8'h01;
      end
      if (wr_en & hi_ok) begin
        if (idx == IDX_RUN)
          run_q <= pwdata[7:0]; // R1
        if (idx == IDX_DBUF)
          dbuf_q <= pwdata[3:0]; // R2
        if (mslot >= 0)
          mode_q[mslot[1:0]] <= pwdata[7:0]; // R3
        if (is_ffc)
          ffc_q[ffsel] <= {2'b11, pwdata[5:4], 2'b11, pwdata[1:0]}; // R5
      end
    end
  end

  // compare storage has no reset; even ones may load via a buffer
  always_ff @(posedge pclk) begin
    for (int i = 0; i < NTMR; i++) begin
      if (wr_en & hi_ok & (cslot == i))
        cbuf_q[i] <= pwdata[7:0]; // R7
      if (wr_en & hi_ok & (cslot == i) &
          !((i % 2 == 0) && dbuf_q[i/2] && run_q[i]))
        cmp_q[i] <= pwdata[7:0]; // R7
      else if ((i % 2 == 0) && dbuf_q[i/2] && clr[i])
        cmp_q[i] <= cbuf_q[i]; // R2
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & bad;
      prdata_q  <= (psel & ~penable & ~pwrite & ~bad) ?
                   {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign timer_output_flipflop = tff_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_STOP_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    !run_q[0] |=> cnt_q[0] == 8'h00) // R1
    else $error("stopped timer counter not zero");
  AST_RUN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en & hi_ok & (idx == IDX_RUN) |=> run_q == $past(pwdata[7:0])) // R1
    else $error("run register not updated");
  AST_DBUF_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en & hi_ok & (idx == IDX_DBUF) |=> dbuf_q == $past(pwdata[3:0])) // R2
    else $error("double buffer bits wrong");
  AST_MODE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en & hi_ok & (mslot == 0)) |=> $stable(mode_q[0])) // R3
    else $error("mode changed without write");
  AST_PWM_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    run_q[0] & (mode_q[0].op == EBT_OP_PWM) & (mode_q[0].pwm == 2'b01)
    & step[0] & (cnt_q[0] == 8'h3e) |=> cnt_q[0] == 8'h00) // R4
    else $error("pwm 6-bit period not wrapped");
  AST_FF_SET: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en & hi_ok & (idx == IDX_FFC02) & (pwdata[3:2] == 2'b01)
    |=> tff_q[0]) // R5
    else $error("flip-flop set command ignored");
  AST_FF_SRC: assert property (@(posedge pclk) disable iff (!presetn)
    ffc_q[0][1] & !ffc_q[0][0] & match[0] & step[0] & !(wr_en & is_ffc)
    |=> tff_q[0] != $past(tff_q[0])) // R6
    else $error("auto inversion missed");
  AST_CMP_READ_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    psel & !penable & !pwrite & hi_ok & (cslot >= 0) |=> pslverr) // R7
    else $error("compare read not refused");
  AST_MATCH_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q[0].op == EBT_OP_8BIT) & match[0] & step[0]
    |=> cnt_q[0] == 8'h00) // R8
    else $error("match did not clear counter");
endmodule : ebt_timer_group

// ==== dv/ebt_timer_group_tb_top.sv ====
// bench for the eight-channel byte timer group
// assumes the core package and timer group are compiled first
`timescale 1ns/100ps
module ebt_timer_group_tb_top;
  import ebt_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  ebt_tick_t   tick;
  logic [7:0]  ext_in;
  logic [3:0]  tff;
  int          miscompares, checks, cyc, g;
  localparam logic [7:0] CMPS [8] = '{IDX_CMP0, IDX_CMP1, IDX_CMP2,
    IDX_CMP3, IDX_CMP4, IDX_CMP5, IDX_CMP6, IDX_CMP7};

  ebt_timer_group #(.NTMR(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tick(tick), .ext_in(ext_in),
    .timer_output_flipflop(tff));

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  // t1 pulses every other cycle so a count really needs a tick
  always @(posedge pclk) tick <= {presetn & ~tick.t1, 3'b000};

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed; the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp,
                       input logic experr);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, experr});
  endtask : rdchk

  // cycles between two changes of one output flip-flop
  task automatic gap(input int b, output int gg);
    int t0, n;
    logic v;
    v = tff[b];
    n = 0;
    while (tff[b] === v && n < 200) begin
      @(posedge pclk);
      n++;
    end
    t0 = cyc;
    v = tff[b];
    n = 0;
    while (tff[b] === v && n < 200) begin
      @(posedge pclk);
      n++;
    end
    gg = cyc - t0;
  endtask : gap

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({28'h0, tff}, 32'h0);
    rdchk(IDX_RUN, 32'h0, 1'b0);
    rdchk(IDX_DBUF, 32'h0, 1'b0);
    rdchk(IDX_MOD01, 32'h0, 1'b0);
    rdchk(IDX_MOD67, 32'h0, 1'b0);
    rdchk(IDX_FFC02, 32'hcc, 1'b0);
    rdchk(IDX_FFC46, 32'hcc, 1'b0);
  endtask : t_reset

  task automatic t_regs;
    logic [7:0] v;
    apb(1'b1, IDX_RUN, 32'ha5);
    rdchk(IDX_RUN, 32'ha5, 1'b0);
    apb(1'b1, IDX_RUN, 32'h0);
    apb(1'b1, IDX_DBUF, 32'hff);
    rdchk(IDX_DBUF, 32'h0f, 1'b0);
    for (int i = 0; i < 16; i++) begin
      v = {i[3:0], 4'h6};
      apb(1'b1, IDX_MOD23, {24'h0, v});
      rdchk(IDX_MOD23, {24'h0, v}, 1'b0);
    end
    apb(1'b1, IDX_MOD23, 32'h0);
    apb(1'b1, IDX_DBUF, 32'h0);
  endtask : t_regs

  task automatic t_wo;
    apb(1'b1, IDX_CMP0, 32'h12);
    chk({31'h0, er}, 32'h0);
    // compare registers refuse reads, so no read-modify-write
    for (int i = 0; i < 8; i++) rdchk(CMPS[i], 32'h0, 1'b1);
    rdchk(8'h30, 32'h0, 1'b1);
  endtask : t_wo

  task automatic t_ffcmd;
    logic [7:0] idx;
    for (int p = 0; p < 2; p++) begin
      idx = p ? IDX_FFC46 : IDX_FFC02;
      apb(1'b1, idx, 32'h44);
      @(posedge pclk);
      chk({30'h0, tff[2*p+:2]}, 32'h3);
      apb(1'b1, idx, 32'h88);
      @(posedge pclk);
      chk({30'h0, tff[2*p+:2]}, 32'h0);
      apb(1'b1, idx, 32'h00);
      @(posedge pclk);
      chk({30'h0, tff[2*p+:2]}, 32'h3);
      apb(1'b1, idx, 32'hcc);
      @(posedge pclk);
      chk({30'h0, tff[2*p+:2]}, 32'h3);
      apb(1'b1, idx, 32'h33);
      rdchk(idx, 32'hff, 1'b0);
      apb(1'b1, idx, 32'h88);
    end
  endtask : t_ffcmd

  task automatic t_match;
    apb(1'b1, IDX_MOD01, {24'h0, EBT_OP_8BIT, 6'h05});
    apb(1'b1, IDX_CMP0, 32'h03);
    apb(1'b1, IDX_CMP1, 32'h05);
    apb(1'b1, IDX_FFC02, 32'hca);
    apb(1'b1, IDX_RUN, 32'h03);
    // tick every second cycle: period is compare plus one ticks, twice that in cycles
    gap(0, g);
    chk(g, 8);
    apb(1'b1, IDX_FFC02, 32'hcb);
    gap(0, g);
    gap(0, g);
    chk(g, 12);
    apb(1'b1, IDX_RUN, 32'h0);
    repeat (4) @(posedge pclk);
    g = tff[0];
    repeat (40) @(posedge pclk);
    chk(tff[0], g[0]);
    // pwm 6-bit cycle: one inversion per 63 ticks of t1
    apb(1'b1, IDX_MOD01, {24'h0, EBT_OP_PWM, 6'h15});
    apb(1'b1, IDX_CMP0, 32'h10);
    apb(1'b1, IDX_FFC02, 32'hca);
    apb(1'b1, IDX_RUN, 32'h01);
    gap(0, g);
    chk(g, 126);
    apb(1'b1, IDX_RUN, 32'h0);
  endtask : t_match

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_in = 8'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_wo();
    t_ffcmd();
    t_match();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    give_verdict();
  end
endmodule : ebt_timer_group_tb_top
